/* File: ovf_consts.vh */
// Constants for the open-loop voltage-per-frequency motor control block
`ifndef OVF_CONSTS_VH
`define OVF_CONSTS_VH
// Register byte offsets
`define OVF_REG_CTRL      8'h00
`define OVF_REG_ZSV       8'h04
`define OVF_REG_CSV       8'h08
`define OVF_REG_CSF       8'h0c
`define OVF_REG_CCF       8'h10
`define OVF_REG_MEC       8'h14
`define OVF_REG_FADE_LO   8'h18
`define OVF_REG_FADE_HI   8'h1c
`define OVF_REG_FILT      8'h20
`define OVF_REG_SLIP_MAX  8'h24
`define OVF_REG_VCOMP_MAX 8'h28
`define OVF_REG_TILT      8'h2c
`define OVF_REG_GAINS     8'h30
`define OVF_REG_DECEL     8'h34
`define OVF_REG_SPEED     8'h38
`define OVF_REG_NAMEPLATE 8'h3c
`define OVF_REG_STATUS    8'h40
`define OVF_REG_MASK      8'h44
`define OVF_REG_FREQ_OUT  8'h48
`define OVF_REG_VOLT_OUT  8'h4c
`define OVF_REG_CUR_OUT   8'h50
// Control register fields
`define OVF_CTRL_SLIP_EN  0
`define OVF_CTRL_RUN      1
// Status register fields
`define OVF_ST_DELAY_FLT  0
`define OVF_ST_TILT       1
`define OVF_ST_DONE       2
// Reset values
`define OVF_RST_VCOMP_MAX 16'h0050
`define OVF_RST_DECEL     16'h0001
// Filter shift limit
`define OVF_FILT_MAX      4'hf
`endif

/* File: ovf_motor_ctrl.v */
// Open-loop voltage-per-frequency motor control with AXI4-Lite registers
//
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
// Overview of operation
// - Voltage follows three-point voltage-frequency curve
// - Nameplate entry preloads the five curve settings
// - Below lower threshold: full minimum current
// - Above upper threshold: minimum current zero
// - Between thresholds current falls with frequency
// - Slip compensation only when enabled
// - Filtered current adds slip frequency
// - Filtered current adds compensation voltage
// - Below lower threshold slip compensation off
// - Above upper threshold slip compensation full
// - Slip weight rises, complementing current weight
// - Over tilt limit, setpoint reduced linearly
// - Emergency input low ramps down at deceleration
// - After stop, fault until input reasserted
// - Compensation voltage clamped, default 80
// - Slip frequency clamped to maximum
`include "ovf_consts.vh"
module ovf_motor_ctrl #(
  parameter W = 16
) (
  input  wire          sys_clk_i,
  input  wire          rstn_i,
  input  wire [7:0]    s_axi_awaddr,
  input  wire          s_axi_awvalid,
  output wire          s_axi_awready,
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  input  wire          s_axi_wvalid,
  output wire          s_axi_wready,
  output reg  [1:0]    s_axi_bresp,
  output reg           s_axi_bvalid,
  input  wire          s_axi_bready,
  input  wire [7:0]    s_axi_araddr,
  input  wire          s_axi_arvalid,
  output wire          s_axi_arready,
  output reg  [31:0]   s_axi_rdata,
  output reg  [1:0]    s_axi_rresp,
  output reg           s_axi_rvalid,
  input  wire          s_axi_rready,
  input  wire [W-1:0]  motor_current_i,
  input  wire          current_sign_i,
  input  wire [W-1:0]  nameplate_voltage_i,
  input  wire [W-1:0]  nameplate_frequency_i,
  input  wire          estop_run_n_i,
  output reg  [W-1:0]  stator_frequency_o,
  output reg           frequency_negative_o,
  output reg  [W-1:0]  motor_voltage_o,
  output reg  [W-1:0]  minimum_current_o,
  output reg           delay_active_fault_o,
  output wire          irq_o
);
  // Settings
  reg  [1:0]   ctrl_q;
  reg  [W-1:0] zero_speed_voltage_q, curve_start_voltage_q, curve_start_frequency_q, curve_corner_frequency_q;
  reg  [W-1:0] minimum_energising_current_q, lower_fade_threshold_q, upper_fade_threshold_q;
  reg  [3:0]   motor_current_filter_q;
  reg  [W-1:0] max_slip_frequency_q, max_slip_comp_voltage_q, tilt_limit_q, speed_setpoint_q, decel_q;
  reg  [7:0]   slip_gain_q, volt_gain_q, tilt_gain_q;
  reg  [2:0]   status_q, mask_q;
  // Run state
  reg  [W-1:0] speed_q, filt_q;
  reg  [W+15:0] filt_acc_q;
  reg          stopping_q;
  reg  [1:0]   estop_sync_q;
  wire         estop_ok = estop_sync_q[1];

  // Two-flop synchroniser for the emergency input pin
  always @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      estop_sync_q <= 2'b00;
    else
      estop_sync_q <= {estop_sync_q[0], estop_run_n_i};
  end

  // AXI write: address and data accepted in either order
  reg          aw_got_q, w_got_q;
  reg  [7:0]   aw_q;
  reg  [31:0]  wd_q;
  reg  [3:0]   ws_q;
  assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_q && !s_axi_bvalid;
  wire        aw_now = aw_got_q | s_axi_awvalid;
  wire        w_now  = w_got_q | s_axi_wvalid;
  wire [7:0]  wa     = aw_got_q ? aw_q : s_axi_awaddr;
  wire [31:0] wdat   = w_got_q ? wd_q : s_axi_wdata;
  wire [3:0]  wstb   = w_got_q ? ws_q : s_axi_wstrb;
  wire        wr_go  = aw_now && w_now && !s_axi_bvalid;
  wire [31:0] wm     = {{8{wstb[3]}}, {8{wstb[2]}}, {8{wstb[1]}}, {8{wstb[0]}}};
  wire [W-1:0] wv    = wdat[W-1:0] & wm[W-1:0];
  wire         wr_ok = (wa[1:0] == 2'b00) && (wa <= `OVF_REG_CUR_OUT);

  // Fade weight in 8-bit fraction, clamped at threshold endpoints
  reg  [W-1:0] span, rel;
  reg  [8:0]   slip_w;
  reg  [W+8:0] wq, quo;
  always @*
  begin
    span = upper_fade_threshold_q - lower_fade_threshold_q;
    rel  = stator_frequency_o - lower_fade_threshold_q;
    wq   = {9'h000, rel} << 8;
    quo  = {W+9{1'b0}};
    if (stator_frequency_o <= lower_fade_threshold_q)
      slip_w = 9'h000;
    else if (stator_frequency_o >= upper_fade_threshold_q || span == {W{1'b0}})
      slip_w = 9'h100;
    else
    begin
      // Quotient stays below 256 because rel is below span here
      quo    = wq / {9'h000, span};
      slip_w = quo[8:0];
    end
  end
  wire [8:0] cur_w = 9'h100 - slip_w;

  // Voltage curve: zero-speed to start point, then to corner
  reg  [W-1:0] curve_v, nameplate_voltage_q;
  reg  [2*W-1:0] num, qv;
  reg  [W-1:0] dv, df, fx;
  always @*
  begin
    num = {2*W{1'b0}};
    qv  = {2*W{1'b0}};
    dv  = {W{1'b0}};
    df  = {W{1'b0}};
    fx  = speed_q;
    if (fx <= curve_start_frequency_q)
    begin
      dv = curve_start_voltage_q - zero_speed_voltage_q;
      num = dv * fx;
      if (curve_start_frequency_q != {W{1'b0}})
        qv = num / curve_start_frequency_q;
      curve_v = (curve_start_frequency_q == {W{1'b0}}) ? curve_start_voltage_q :
                zero_speed_voltage_q + qv[W-1:0];
    end
    else if (fx >= curve_corner_frequency_q)
      curve_v = nameplate_voltage_q;
    else
    begin
      dv  = nameplate_voltage_q - curve_start_voltage_q;
      df  = curve_corner_frequency_q - curve_start_frequency_q;
      num = dv * (fx - curve_start_frequency_q);
      qv  = num / df;
      curve_v = curve_start_voltage_q + qv[W-1:0];
    end
  end

  // Slip terms from filtered current, clamped then faded in
  wire [W+7:0]  slip_raw = filt_q * slip_gain_q;
  wire [W+7:0]  volt_raw = filt_q * volt_gain_q;
  wire [W-1:0]  slip_c = (slip_raw[W+7:4] > {4'h0, max_slip_frequency_q}) ? max_slip_frequency_q
                         : slip_raw[W+3:4];
  wire [W-1:0]  volt_c = (volt_raw[W+7:4] > {4'h0, max_slip_comp_voltage_q}) ? max_slip_comp_voltage_q
                         : volt_raw[W+3:4];
  wire          slip_on = ctrl_q[`OVF_CTRL_SLIP_EN];
  wire [W+8:0]  slip_f = slip_on ? slip_c * slip_w : {W+9{1'b0}};
  wire [W+8:0]  volt_f = slip_on ? volt_c * slip_w : {W+9{1'b0}};
  wire [W+8:0]  mc_f   = minimum_energising_current_q * cur_w;

  // Tilting protection: setpoint lowered by excess current
  wire          tilting = filt_q > tilt_limit_q;
  wire [W+7:0]  over    = (filt_q - tilt_limit_q) * tilt_gain_q;
  wire [W-1:0]  cut     = over[W+3:4];
  wire [W-1:0]  target  = !tilting ? speed_setpoint_q :
                          (cut >= speed_setpoint_q ? {W{1'b0}} : speed_setpoint_q - cut);
  wire          run_req = ctrl_q[`OVF_CTRL_RUN] && estop_ok && !delay_active_fault_o;
  wire          stop_done = stopping_q && speed_q == {W{1'b0}};
  wire [W+15:0] filt_sh   = filt_acc_q >> motor_current_filter_q;

  // Core datapath: filter, ramp, outputs
  always @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      filt_acc_q <= {W+16{1'b0}};
      filt_q <= {W{1'b0}};
      speed_q <= {W{1'b0}};
      stopping_q <= 1'b0;
      delay_active_fault_o <= 1'b0;
      stator_frequency_o <= {W{1'b0}};
      frequency_negative_o <= 1'b0;
      motor_voltage_o <= {W{1'b0}};
      minimum_current_o <= {W{1'b0}};
    end
    else
    begin
      // First-order IIR, shift sets time constant
      filt_acc_q <= filt_acc_q - filt_sh + {16'h0000, motor_current_i};
      filt_q <= filt_sh[W-1:0];
      if (!estop_ok && speed_q != {W{1'b0}})
        stopping_q <= 1'b1;
      else if (stop_done)
        stopping_q <= 1'b0;
      // Ramp down at configured deceleration rather than snap to zero
      if (stopping_q || !estop_ok)
        speed_q <= (speed_q > decel_q) ? speed_q - decel_q : {W{1'b0}};
      else if (run_req)
        speed_q <= target;
      else
        speed_q <= {W{1'b0}};
      if (stop_done)
        delay_active_fault_o <= 1'b1;
      else if (estop_ok && !stopping_q)
        delay_active_fault_o <= 1'b0;
      // Signed current shifts frequency up or down
      if (current_sign_i && slip_f[W+7:8] > speed_q)
      begin
        stator_frequency_o <= slip_f[W+7:8] - speed_q;
        frequency_negative_o <= 1'b1;
      end
      else
      begin
        stator_frequency_o <= current_sign_i ? speed_q - slip_f[W+7:8] : speed_q + slip_f[W+7:8];
        frequency_negative_o <= 1'b0;
      end
      motor_voltage_o <= curve_v + volt_f[W+7:8];
      minimum_current_o <= mc_f[W+7:8];
    end
  end

  // Register file and write channel
  wire [2:0] ev = {stop_done, tilting, stop_done};
  always @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      aw_q <= 8'h00;
      wd_q <= 32'h0000_0000;
      ws_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      ctrl_q <= 2'b00;
      zero_speed_voltage_q <= {W{1'b0}};
      curve_start_voltage_q <= {W{1'b0}};
      curve_start_frequency_q <= {W{1'b0}};
      curve_corner_frequency_q <= {W{1'b0}};
      nameplate_voltage_q <= {W{1'b0}};
      minimum_energising_current_q <= {W{1'b0}};
      lower_fade_threshold_q <= {W{1'b0}};
      upper_fade_threshold_q <= {W{1'b0}};
      motor_current_filter_q <= 4'h0;
      max_slip_frequency_q <= {W{1'b0}};
      max_slip_comp_voltage_q <= `OVF_RST_VCOMP_MAX;
      tilt_limit_q <= {W{1'b1}};
      slip_gain_q <= 8'h00;
      volt_gain_q <= 8'h00;
      tilt_gain_q <= 8'h00;
      decel_q <= `OVF_RST_DECEL;
      speed_setpoint_q <= {W{1'b0}};
      status_q <= 3'b000;
      mask_q <= 3'b000;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready && !wr_go)
      begin
        aw_got_q <= 1'b1;
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready && !wr_go)
      begin
        w_got_q <= 1'b1;
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      // Sticky events; a new event wins over a same-cycle clear
      status_q <= (status_q & ~((wr_go && wa == `OVF_REG_STATUS) ? wdat[2:0] & wm[2:0] : 3'b000)) | ev;
      if (wr_go)
      begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
        case (wa)
          `OVF_REG_CTRL:      ctrl_q <= wv[1:0];
          `OVF_REG_ZSV:       zero_speed_voltage_q <= wv;
          `OVF_REG_CSV:       curve_start_voltage_q <= wv;
          `OVF_REG_CSF:       curve_start_frequency_q <= wv;
          `OVF_REG_CCF:       curve_corner_frequency_q <= wv;
          `OVF_REG_MEC:       minimum_energising_current_q <= wv;
          `OVF_REG_FADE_LO:   lower_fade_threshold_q <= wv;
          `OVF_REG_FADE_HI:   upper_fade_threshold_q <= wv;
          `OVF_REG_FILT:      motor_current_filter_q <= wv[3:0];
          `OVF_REG_SLIP_MAX:  max_slip_frequency_q <= wv;
          `OVF_REG_VCOMP_MAX: max_slip_comp_voltage_q <= wv;
          `OVF_REG_TILT:      tilt_limit_q <= wv;
          `OVF_REG_GAINS:
          begin
            slip_gain_q <= wdat[7:0] & wm[7:0];
            volt_gain_q <= wdat[15:8] & wm[15:8];
            tilt_gain_q <= wdat[23:16] & wm[23:16];
          end
          `OVF_REG_DECEL:     decel_q <= wv;
          `OVF_REG_SPEED:     speed_setpoint_q <= wv;
          `OVF_REG_NAMEPLATE:
          begin
            // Preload the whole curve from nameplate voltage and frequency
            nameplate_voltage_q <= nameplate_voltage_i;
            zero_speed_voltage_q <= nameplate_voltage_i >> 5;
            curve_start_voltage_q <= nameplate_voltage_i >> 4;
            curve_start_frequency_q <= nameplate_frequency_i >> 5;
            curve_corner_frequency_q <= nameplate_frequency_i;
          end
          `OVF_REG_MASK:      mask_q <= wdat[2:0];
          default:            ;
        endcase
      end
    end
  end
  assign irq_o = |(status_q & mask_q);

  // Read channel, one cycle after address taken
  assign s_axi_arready = !s_axi_rvalid;
  reg [31:0] rd;
  always @*
  begin
    rd = 32'h0000_0000;
    case (s_axi_araddr)
      `OVF_REG_CTRL:      rd = {30'h0, ctrl_q};
      `OVF_REG_ZSV:       rd = {{32-W{1'b0}}, zero_speed_voltage_q};
      `OVF_REG_CSV:       rd = {{32-W{1'b0}}, curve_start_voltage_q};
      `OVF_REG_CSF:       rd = {{32-W{1'b0}}, curve_start_frequency_q};
      `OVF_REG_CCF:       rd = {{32-W{1'b0}}, curve_corner_frequency_q};
      `OVF_REG_MEC:       rd = {{32-W{1'b0}}, minimum_energising_current_q};
      `OVF_REG_FADE_LO:   rd = {{32-W{1'b0}}, lower_fade_threshold_q};
      `OVF_REG_FADE_HI:   rd = {{32-W{1'b0}}, upper_fade_threshold_q};
      `OVF_REG_FILT:      rd = {28'h0, motor_current_filter_q};
      `OVF_REG_SLIP_MAX:  rd = {{32-W{1'b0}}, max_slip_frequency_q};
      `OVF_REG_VCOMP_MAX: rd = {{32-W{1'b0}}, max_slip_comp_voltage_q};
      `OVF_REG_TILT:      rd = {{32-W{1'b0}}, tilt_limit_q};
      `OVF_REG_GAINS:     rd = {8'h00, tilt_gain_q, volt_gain_q, slip_gain_q};
      `OVF_REG_DECEL:     rd = {{32-W{1'b0}}, decel_q};
      `OVF_REG_SPEED:     rd = {{32-W{1'b0}}, speed_setpoint_q};
      `OVF_REG_NAMEPLATE: rd = {{32-W{1'b0}}, nameplate_voltage_q};
      `OVF_REG_STATUS:    rd = {29'h0, status_q};
      `OVF_REG_MASK:      rd = {29'h0, mask_q};
      `OVF_REG_FREQ_OUT:  rd = {{31-W{1'b0}}, frequency_negative_o, stator_frequency_o};
      `OVF_REG_VOLT_OUT:  rd = {{32-W{1'b0}}, motor_voltage_o};
      `OVF_REG_CUR_OUT:   rd = {{32-W{1'b0}}, minimum_current_o};
      default:            rd = 32'h0000_0000;
    endcase
  end
  always @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd;
      s_axi_rresp <= (s_axi_araddr[1:0] == 2'b00 && s_axi_araddr <= `OVF_REG_CUR_OUT) ? 2'b00 : 2'b10;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule // ovf_motor_ctrl

/* File: ovf_motor_ctrl_props.sv */
// Port checker for the voltage-per-frequency motor control block
`timescale 1ns/100ps
module ovf_chk #(
  parameter W = 16
) (
  input wire         sys_clk_i,
  input wire         rstn_i,
  input wire [7:0]   s_axi_awaddr,
  input wire         s_axi_awvalid,
  input wire         s_axi_awready,
  input wire         s_axi_wvalid,
  input wire         s_axi_wready,
  input wire [1:0]   s_axi_bresp,
  input wire         s_axi_bvalid,
  input wire         s_axi_bready,
  input wire [7:0]   s_axi_araddr,
  input wire         s_axi_arvalid,
  input wire         s_axi_arready,
  input wire [31:0]  s_axi_rdata,
  input wire [1:0]   s_axi_rresp,
  input wire         s_axi_rvalid,
  input wire         s_axi_rready,
  input wire         estop_run_n_i,
  input wire [W-1:0] stator_frequency_o,
  input wire         delay_active_fault_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  // Both write channels taken at one edge
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Estop pin seen low long enough to pass the synchroniser
  sequence s_stop_held;
    (!estop_run_n_i) [*4];
  endsequence
  property p_b_after; s_wr_both |=> s_axi_bvalid; endproperty
  a_b_after: assert property (p_b_after) else $error("write answer missing");
  property p_b_bad; s_wr_both ##0 (s_axi_awaddr > 8'h50) |=> s_axi_bvalid && s_axi_bresp == 2'b10; endproperty
  a_b_bad: assert property (p_b_bad) else $error("unmapped write not refused");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_ar; s_axi_arready == !s_axi_rvalid; endproperty
  a_ar: assert property (p_ar) else $error("read address ready wrong");
  property p_r_bad;
    s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h50 |=> s_axi_rvalid && s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0;
  endproperty
  a_r_bad: assert property (p_r_bad) else $error("unmapped read not refused");
  property p_rst; $rose(rstn_i) |-> !s_axi_bvalid && !s_axi_rvalid && stator_frequency_o == 0 && !delay_active_fault_o; endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
  property p_fault_set; $rose(delay_active_fault_o) |-> !$past(estop_run_n_i, 2) || !$past(estop_run_n_i, 3); endproperty
  a_fault_set: assert property (p_fault_set) else $error("fault without stop");
  property p_fault_clr; $fell(delay_active_fault_o) |-> $past(estop_run_n_i, 2) || $past(estop_run_n_i, 3); endproperty
  a_fault_clr: assert property (p_fault_clr) else $error("fault cleared while stopped");
  property p_fault_stop; delay_active_fault_o && $past(delay_active_fault_o) |-> stator_frequency_o == 0; endproperty
  a_fault_stop: assert property (p_fault_stop) else $error("run while fault");
  property p_ramp; s_stop_held |-> stator_frequency_o <= $past(stator_frequency_o); endproperty
  a_ramp: assert property (p_ramp) else $error("frequency rose during stop");
endmodule // ovf_chk

bind ovf_motor_ctrl ovf_chk #(.W(W)) ovf_chk_inst (
  .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .estop_run_n_i(estop_run_n_i), .stator_frequency_o(stator_frequency_o),
  .delay_active_fault_o(delay_active_fault_o));

/* File: ovf_motor_model.sv */
// Motor and elevator controller model for the motor control block
`timescale 1ns/100ps
module ovf_motor_model (
  input  wire        sys_clk_i,
  input  wire [15:0] motor_voltage_i,
  input  wire [15:0] load_i,
  input  wire        regen_i,
  input  wire        stop_req_i,
  output reg  [15:0] motor_current_o,
  output reg         current_sign_o,
  output reg         estop_run_n_o
);
  initial
  begin
    motor_current_o = 16'h0000;
    current_sign_o  = 1'b0;
    estop_run_n_o   = 1'b1;
  end
  // Current grows with load and applied voltage, with no noise, cleaner than a real motor
  always @(posedge sys_clk_i)
  begin
    motor_current_o <= load_i + (motor_voltage_i >> 6);
    current_sign_o  <= regen_i;
    estop_run_n_o   <= !stop_req_i;
  end
endmodule // ovf_motor_model

/* File: ovf_motor_ctrl_bench.sv */
// Self-checking bench for the motor control block
`timescale 1ns/100ps
`include "ovf_consts.vh"
`define CHK(a, e) begin compares = compares + 1; if ((a) !== (e)) begin mismatches = mismatches + 1; \
  $display("[ERR] t=%0t got %h exp %h", $time, (a), (e)); end end
module ovf_motor_ctrl_bench;
  reg         clk, rstn, awv, wv, brdy, arv, rrdy, regen, stop_req;
  reg  [7:0]  awa, ara;
  reg  [31:0] wd, q;
  reg  [15:0] load, np_v, np_f;
  reg  [1:0]  r;
  wire        awr, wr_rdy, bv, arr, rv, sign, estop_n, neg, fault, irq;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [15:0] cur, freq, volt, imin;
  integer     mismatches, compares;
  ovf_motor_ctrl ovf_motor_ctrl_inst (
    .sys_clk_i(clk), .rstn_i(rstn), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rrdy),
    .motor_current_i(cur), .current_sign_i(sign), .nameplate_voltage_i(np_v), .nameplate_frequency_i(np_f),
    .estop_run_n_i(estop_n), .stator_frequency_o(freq), .frequency_negative_o(neg), .motor_voltage_o(volt),
    .minimum_current_o(imin), .delay_active_fault_o(fault), .irq_o(irq));
  ovf_motor_model ovf_motor_model_inst (
    .sys_clk_i(clk), .motor_voltage_i(volt), .load_i(load), .regen_i(regen), .stop_req_i(stop_req),
    .motor_current_o(cur), .current_sign_o(sign), .estop_run_n_o(estop_n));
  // Clock, 20 ns period
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task close_out;
    begin
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  // One AXI4-Lite transfer; ready is looked at mid-cycle, where it holds its value for the next edge
  task axi(input wr, input [7:0] a, input [31:0] d);
    reg fa, fw, fb, ta, tw, tb;
    integer n;
    begin
      fa = 1'b1; fw = wr; fb = 1'b1; n = 0;
      // Response ready stays up between transfers, so it is set once per call
      if (wr) begin awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; brdy <= 1'b1; rrdy <= 1'b0; end
      else begin ara <= a; arv <= 1'b1; rrdy <= 1'b1; brdy <= 1'b0; end
      while ((fa || fw || fb) && n < 64)
      begin
        @(negedge clk);
        ta = fa && (wr ? awr : arr);
        tw = fw && wr_rdy;
        tb = fb && (wr ? bv : rv);
        if (tb) begin r = wr ? bresp : rresp; q = rdata; end
        @(posedge clk);
        if (ta) begin fa = 1'b0; awv <= 1'b0; arv <= 1'b0; end
        if (tw) begin fw = 1'b0; wv <= 1'b0; end
        if (tb) fb = 1'b0;
        n = n + 1;
      end
      if (n >= 64) begin mismatches = mismatches + 1; close_out; end
    end
  endtask
  // Bounded wait for the output frequency to pass a level
  task wait_f(input [15:0] f, input up);
    integer n;
    begin
      n = 0;
      while (!(up ? freq >= f : freq <= f) && n < 4000) begin @(posedge clk); n = n + 1; end
      if (n >= 4000) begin mismatches = mismatches + 1; close_out; end
    end
  endtask
  task t_regs;
    begin
      axi(0, `OVF_REG_VCOMP_MAX, 0); `CHK(q, 32'h0000_0050)
      axi(0, `OVF_REG_DECEL, 0); `CHK(q, 32'h0000_0001)
      axi(0, 8'h80, 0); `CHK(r, 2'b10)
      axi(1, 8'h80, 32'h1234); `CHK(r, 2'b10)
      `CHK(irq, 1'b0)
      $display("t_regs done");
    end
  endtask
  task t_preload;
    begin
      np_v <= 16'h0320; np_f <= 16'h0100;
      axi(1, `OVF_REG_NAMEPLATE, 0);
      axi(0, `OVF_REG_ZSV, 0); `CHK(q, 32'h19)
      axi(0, `OVF_REG_CSV, 0); `CHK(q, 32'h32)
      axi(0, `OVF_REG_CSF, 0); `CHK(q, 32'h8)
      axi(0, `OVF_REG_CCF, 0); `CHK(q, 32'h100)
      axi(0, `OVF_REG_NAMEPLATE, 0); `CHK(q, 32'h320)
      $display("t_preload done");
    end
  endtask
  task t_fade;
    begin
      axi(1, `OVF_REG_MEC, 32'h123); axi(1, `OVF_REG_FADE_LO, 32'h40); axi(1, `OVF_REG_FADE_HI, 32'h80);
      repeat (3) @(posedge clk);
      `CHK(imin, 16'h0123)
      // Setpoint is taken at once, so each level is set directly
      axi(1, `OVF_REG_SPEED, 32'h60); axi(1, `OVF_REG_CTRL, 32'h2);
      repeat (6) @(posedge clk);
      `CHK(freq, 16'h0060)
      `CHK(imin, 16'h0091)
      `CHK(volt, 16'h013c)
      axi(1, `OVF_REG_SPEED, 32'h40); repeat (6) @(posedge clk);
      `CHK(imin, 16'h0123)
      axi(1, `OVF_REG_SPEED, 32'hc8); repeat (6) @(posedge clk);
      `CHK(imin, 16'h0000)
      `CHK(freq, 16'h00c8)
      `CHK(volt, 16'h0276)
      $display("t_fade done");
    end
  endtask
  task t_slip;
    begin
      load <= 16'h0100;
      axi(1, `OVF_REG_FILT, 0); axi(1, `OVF_REG_SLIP_MAX, 32'h20); axi(1, `OVF_REG_GAINS, 32'h1010);
      repeat (8) @(posedge clk);
      `CHK(freq, 16'h00c8)
      axi(1, `OVF_REG_CTRL, 32'h3);
      repeat (50) @(posedge clk);
      `CHK(freq, 16'h00e8)
      `CHK(volt, 16'h02c6)
      regen <= 1'b1; repeat (50) @(posedge clk);
      `CHK(freq, 16'h00a8)
      `CHK(neg, 1'b0)
      regen <= 1'b0; load <= 16'h0000;
      $display("t_slip done");
    end
  endtask
  task t_estop;
    begin
      stop_req <= 1'b1;
      wait_f(16'h0000, 1'b0); repeat (4) @(posedge clk);
      `CHK(fault, 1'b1)
      axi(0, `OVF_REG_STATUS, 0); `CHK(q[`OVF_ST_DELAY_FLT], 1'b1)
      axi(1, `OVF_REG_MASK, 32'h1); `CHK(irq, 1'b1)
      stop_req <= 1'b0; repeat (6) @(posedge clk);
      `CHK(fault, 1'b0)
      `CHK(irq, 1'b1)
      axi(1, `OVF_REG_STATUS, 32'h1); @(posedge clk); `CHK(irq, 1'b0)
      $display("t_estop done");
    end
  endtask
  // Main sequence
  initial
  begin
    mismatches = 0; compares = 0;
    rstn = 1'b0; awv = 1'b0; wv = 1'b0; brdy = 1'b0; arv = 1'b0; rrdy = 1'b0;
    awa = 8'h00; ara = 8'h00; wd = 32'h0; load = 16'h0000; regen = 1'b0; stop_req = 1'b0;
    np_v = 16'h0000; np_f = 16'h0000;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_regs;
    t_preload;
    t_fade;
    t_slip;
    t_estop;
    close_out;
  end
endmodule // ovf_motor_ctrl_bench
